// ==== sacc_defs.svh ====
// register offsets, field positions, reset values and timing counts
`ifndef SACC_DEFS_SVH
`define SACC_DEFS_SVH

// register byte offsets
`define SACC_CTRL_OFS     6'h00
`define SACC_CHAN_OFS     6'h04
`define SACC_DIFF_OFS     6'h08
`define SACC_GAIN_OFS     6'h0C
`define SACC_RES_LO_OFS   6'h10
`define SACC_RES_HI_OFS   6'h14
`define SACC_WIN_LO_OFS   6'h18
`define SACC_WIN_HI_OFS   6'h1C
`define SACC_IRQ_ST_OFS   6'h20
`define SACC_IRQ_MASK_OFS 6'h24
`define SACC_STATUS_OFS   6'h28

// control field positions
`define SACC_CTRL_EN      0
`define SACC_CTRL_LEFT    1
`define SACC_CTRL_TRIG    2
`define SACC_CTRL_SWSTART 4
`define SACC_CTRL_RSTEN   5

// interrupt status and mask bits
`define SACC_IRQ_DONE     0
`define SACC_IRQ_WIN      1

// status bits
`define SACC_ST_BUSY      0
`define SACC_ST_EN        1

// reset values and limits
`define SACC_CHAN_RST     4'h0
`define SACC_GAIN_RST     3'h1
`define SACC_GAIN_MAX     3'h5
`define SACC_TEMP_CHAN    4'h8
`define SACC_WIN_LO_RST   16'h0000
`define SACC_WIN_HI_RST   16'hFFFF
`define SACC_RES_W        12

// timing: one conversion slot at full throughput
`define SACC_CONV_TIME_NS 10000
`define SACC_CLK_MHZ      200
`define SACC_CONV_CYC     ((`SACC_CONV_TIME_NS * `SACC_CLK_MHZ + 999) / 1000)
`define SACC_TRACK_SLOTS  4

`endif

// ==== sacc_pkg.sv ====
// types shared by the conversion control block
`default_nettype none
package sacc_pkg;
    typedef enum logic [1:0] {TRIG_SW, TRIG_T2, TRIG_T3, TRIG_PIN} sacc_trig_t;
    typedef enum logic [1:0] {SAR_IDLE, SAR_TRACK, SAR_BITS} sacc_sar_state_t;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [5:0]  address;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } sacc_avs_req_t;

    typedef struct packed {
        logic        pwr_en;
        logic        diff;
        logic [3:0]  pos_sel;
        logic [2:0]  neg_sel;
        logic [2:0]  gain;
        logic        track;
        logic [15:0] trial;
    } sacc_afe_t;

    typedef struct packed {
        logic [2:0] ff;
        logic       level;
        logic       rise;
    } sacc_sync_st_t;

    typedef struct packed {
        sacc_sar_state_t state;
        logic [11:0]     cnt;
        logic [3:0]      bitn;
        logic [15:0]     sar;
        logic            done;
    } sacc_sar_st_t;

    typedef struct packed {
        logic        en;
        logic        left;
        sacc_trig_t  trig;
        logic        rst_en;
        logic [3:0]  chan;
        logic [3:0]  diff;
        logic [2:0]  gain;
        logic [15:0] win_lo;
        logic [15:0] win_hi;
        logic [15:0] raw;
        logic [15:0] res_word;
        logic [1:0]  irq_st;
        logic [1:0]  irq_mask;
        logic        rd_ack;
        logic [31:0] rdata;
        sacc_afe_t   afe;
    } sacc_regs_t;
endpackage : sacc_pkg
`default_nettype wire

// ==== sacc_sync.sv ====
// three-stage synchroniser with agreement filter and rise pulse
`default_nettype none
module sacc_sync (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic reset,
    // asynchronous input
    input  wire logic async_in,
    // synchronised outputs
    output logic      level,
    output logic      rise
);
    import sacc_pkg::*;

    sacc_sync_st_t st_q;
    sacc_sync_st_t st_d;

    // shift chain; level follows once stages two and three agree
    always_comb begin
        st_d      = st_q;
        st_d.ff   = {st_q.ff[1:0], async_in};
        st_d.rise = 1'b0;
        if (st_q.ff[1] == st_q.ff[2] && st_q.ff[2] != st_q.level) begin
            st_d.level = st_q.ff[2];
            st_d.rise  = st_q.ff[2];
        end
    end

    // state register
    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign level = st_q.level;
    assign rise  = st_q.rise;
endmodule : sacc_sync
`default_nettype wire

// ==== sacc_sar.sv ====
// successive-approximation sequencer: track phase then one slot per bit
`default_nettype none
`include "sacc_defs.svh"
module sacc_sar #(
    parameter int RES_W    = `SACC_RES_W,
    parameter int CONV_CYC = `SACC_CONV_CYC
) (
    // clock and reset
    input  wire logic  core_clk,
    input  wire logic  reset,
    // control
    input  wire logic  start,
    input  wire logic  abort,
    input  wire logic  cmp,
    // status and result
    output logic       busy,
    output logic       done,
    output logic [15:0] result,
    output logic       track,
    output logic [15:0] trial
);
    import sacc_pkg::*;

    localparam int BIT_CYC   = CONV_CYC / (RES_W + `SACC_TRACK_SLOTS);
    localparam int TRACK_CYC = BIT_CYC * `SACC_TRACK_SLOTS;
    localparam int TOTAL_CYC = TRACK_CYC + RES_W * BIT_CYC;

    sacc_sar_st_t st_q;
    sacc_sar_st_t st_d;
    logic [15:0]  cur_bit;

    assign cur_bit = 16'h0001 << st_q.bitn;

    // sequencer; runs regardless of any core halt
    always_comb begin
        st_d      = st_q;
        st_d.done = 1'b0;
        case (st_q.state)
            SAR_IDLE: begin
                if (start && !abort) begin
                    st_d.state = SAR_TRACK;
                    st_d.cnt   = 12'(TRACK_CYC - 1);
                    st_d.sar   = 16'h0000;
                end
            end
            SAR_TRACK: begin // new starts ignored here
                st_d.cnt = st_q.cnt - 12'h001;
                if (st_q.cnt == 12'h000) begin
                    st_d.state = SAR_BITS;
                    st_d.cnt   = 12'(BIT_CYC - 1);
                    st_d.bitn  = 4'(RES_W - 1);
                end
            end
            SAR_BITS: begin
                st_d.cnt = st_q.cnt - 12'h001;
                if (st_q.cnt == 12'h000) begin
                    if (cmp) begin
                        st_d.sar = st_q.sar | cur_bit;
                    end
                    st_d.cnt  = 12'(BIT_CYC - 1);
                    st_d.bitn = st_q.bitn - 4'h1;
                    if (st_q.bitn == 4'h0) begin // ready for the next start at once
                        st_d.state = SAR_IDLE;
                        st_d.done  = 1'b1;
                    end
                end
            end
            default: begin
                st_d.state = SAR_IDLE;
            end
        endcase
        if (abort) begin // shutdown drops a conversion
            st_d.state = SAR_IDLE;
            st_d.done  = 1'b0;
        end
    end

    // state register
    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign busy   = st_q.state != SAR_IDLE;
    assign done   = st_q.done;
    assign result = st_q.sar;
    assign track  = st_q.state == SAR_TRACK;
    assign trial  = (st_q.state == SAR_BITS) ? (st_q.sar | cur_bit) : 16'h0000;

    // busy-cycle counter for the length check
    logic [11:0] bcnt_q;
    always_ff @(posedge core_clk) begin
        if (reset) begin
            bcnt_q <= 12'h000;
        end else begin
            bcnt_q <= busy ? bcnt_q + 12'h001 : 12'h000;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    conv_len_a: assert property (done |-> bcnt_q == 12'(TOTAL_CYC))
        else $error("conversion length wrong");
    start_ignored_a: assert property (busy && start && st_q.cnt != 12'h000 && !abort
        |=> st_q.cnt == $past(st_q.cnt) - 12'h001)
        else $error("start disturbed running conversion");
endmodule : sacc_sar
`default_nettype wire

// ==== sacc_top.sv ====
// conversion control: register slave, triggers, result, window and interrupts
//
// Notes on behaviour
// - conversion starts on software, timer 2, timer 3 or pin edge, as selected.
// - completion sets a sticky, pollable status bit and requests an interrupt.
// - result latched into low and high byte registers in one update.
// - result placed right or left aligned per software setting.
// - window interrupt only when result lies between the two limits.
// - nine channels: eight external plus the temperature sensor.
// - each external pair selectable as two single-ended or one differential.
// - gain from 0.5 to 16 in powers of two, after the multiplexer.
// - shutdown powers the converter down; no conversions then.
// - back-to-back conversions up to 100 thousand samples per second.
// - converter keeps running while the core is halted or stepping.
// - convert-start pin can also request a system reset when enabled.
//
// The register addresses and the Avalon-MM register port were decided locally.
`default_nettype none
`include "sacc_defs.svh"
module sacc_top #(
    parameter int RES_W    = `SACC_RES_W,
    parameter int CONV_CYC = `SACC_CONV_CYC
) (
    // clock and reset
    input  wire logic                core_clk,
    input  wire logic                reset,
    // register bus
    input  wire sacc_pkg::sacc_avs_req_t avs_req,
    output logic [31:0]              avs_readdata,
    output logic                     avs_waitrequest,
    // conversion triggers
    input  wire logic                timer2_ovf,
    input  wire logic                timer3_ovf,
    input  wire logic                external_convert_start_pin,
    // analog front end
    input  wire logic                cmp_out,
    output sacc_pkg::sacc_afe_t      afe,
    // system
    output logic                     pin_reset_req,
    output logic                     irq
);
    import sacc_pkg::*;

    localparam int JUST_SH = 16 - RES_W;

    sacc_regs_t  st_q;
    sacc_regs_t  st_d;
    logic        pin_level;
    logic        pin_rise;
    logic        cmp_level;
    logic        conv_busy;
    logic        conv_done;
    logic [15:0] conv_res;
    logic        conv_track;
    logic [15:0] conv_trial;
    logic        trig_hit;
    logic        sw_start;
    logic [31:0] be_mask;
    logic [31:0] rd_val;
    logic [31:0] wr_val;
    logic        in_window;
    logic [1:0]  irq_set;
    logic [1:0]  irq_clr;

    // pin and comparator enter through synchronisers
    sacc_sync u_pin_sync (
        .core_clk (core_clk),
        .reset    (reset),
        .async_in (external_convert_start_pin),
        .level    (pin_level),
        .rise     (pin_rise)
    );

    sacc_sync u_cmp_sync (
        .core_clk (core_clk),
        .reset    (reset),
        .async_in (cmp_out),
        .level    (cmp_level),
        .rise     ()
    );

    // converter sequencer
    sacc_sar #(
        .RES_W    (RES_W),
        .CONV_CYC (CONV_CYC)
    ) u_sar (
        .core_clk (core_clk),
        .reset    (reset),
        .start    (st_q.en && trig_hit),
        .abort    (!st_q.en),
        .cmp      (cmp_level),
        .busy     (conv_busy),
        .done     (conv_done),
        .result   (conv_res),
        .track    (conv_track),
        .trial    (conv_trial)
    );

    // byte-lane mask for writes
    assign be_mask = {{8{avs_req.byteenable[3]}}, {8{avs_req.byteenable[2]}},
                      {8{avs_req.byteenable[1]}}, {8{avs_req.byteenable[0]}}};

    // register read multiplexer; unmapped reads as zero
    always_comb begin
        rd_val = 32'h0000_0000;
        case (avs_req.address)
            `SACC_CTRL_OFS: begin
                rd_val[`SACC_CTRL_EN]          = st_q.en;
                rd_val[`SACC_CTRL_LEFT]        = st_q.left;
                rd_val[`SACC_CTRL_TRIG +: 2]   = st_q.trig;
                rd_val[`SACC_CTRL_RSTEN]       = st_q.rst_en;
            end
            `SACC_CHAN_OFS:     rd_val[3:0]  = st_q.chan;
            `SACC_DIFF_OFS:     rd_val[3:0]  = st_q.diff;
            `SACC_GAIN_OFS:     rd_val[2:0]  = st_q.gain;
            `SACC_RES_LO_OFS:   rd_val[7:0]  = st_q.res_word[7:0];
            `SACC_RES_HI_OFS:   rd_val[7:0]  = st_q.res_word[15:8];
            `SACC_WIN_LO_OFS:   rd_val[15:0] = st_q.win_lo;
            `SACC_WIN_HI_OFS:   rd_val[15:0] = st_q.win_hi;
            `SACC_IRQ_ST_OFS:   rd_val[1:0]  = st_q.irq_st;
            `SACC_IRQ_MASK_OFS: rd_val[1:0]  = st_q.irq_mask;
            `SACC_STATUS_OFS: begin
                rd_val[`SACC_ST_BUSY] = conv_busy;
                rd_val[`SACC_ST_EN]   = st_q.en;
            end
            default: rd_val = 32'h0000_0000;
        endcase
    end

    // merged write value: untouched lanes keep their contents
    assign wr_val   = (rd_val & ~be_mask) | (avs_req.writedata & be_mask);
    assign sw_start = avs_req.write && avs_req.address == `SACC_CTRL_OFS
                      && avs_req.byteenable[0]
                      && avs_req.writedata[`SACC_CTRL_SWSTART];

    // trigger selection
    always_comb begin
        case (st_q.trig)
            TRIG_SW:  trig_hit = sw_start;
            TRIG_T2:  trig_hit = timer2_ovf;
            TRIG_T3:  trig_hit = timer3_ovf;
            TRIG_PIN: trig_hit = pin_rise;
            default:  trig_hit = 1'b0;
        endcase
    end

    // window test on the raw right-aligned value
    assign in_window = ({4'h0, conv_res[11:0]} & 16'hFFFF) >= st_q.win_lo
                       && ({4'h0, conv_res[11:0]}) <= st_q.win_hi;

    // sticky events and write-one-to-clear
    assign irq_set = {conv_done && in_window, conv_done};
    assign irq_clr = (avs_req.write && avs_req.address == `SACC_IRQ_ST_OFS)
                     ? wr_val[1:0] & avs_req.writedata[1:0] : 2'b00;

    // next-state logic
    always_comb begin
        st_d        = st_q;
        st_d.rd_ack = avs_req.read && !st_q.rd_ack;
        if (avs_req.read && !st_q.rd_ack) begin
            st_d.rdata = rd_val;
        end
        if (avs_req.write) begin
            case (avs_req.address)
                `SACC_CTRL_OFS: begin
                    st_d.en     = wr_val[`SACC_CTRL_EN];
                    st_d.left   = wr_val[`SACC_CTRL_LEFT];
                    st_d.trig   = sacc_trig_t'(wr_val[`SACC_CTRL_TRIG +: 2]);
                    st_d.rst_en = wr_val[`SACC_CTRL_RSTEN];
                end
                `SACC_CHAN_OFS: st_d.chan = wr_val[3:0];
                `SACC_DIFF_OFS: st_d.diff = wr_val[3:0];
                `SACC_GAIN_OFS: begin // codes above x16 saturate
                    st_d.gain = (wr_val[2:0] > `SACC_GAIN_MAX) ? `SACC_GAIN_MAX
                                                                : wr_val[2:0];
                end
                `SACC_WIN_LO_OFS:   st_d.win_lo   = wr_val[15:0];
                `SACC_WIN_HI_OFS:   st_d.win_hi   = wr_val[15:0];
                `SACC_IRQ_MASK_OFS: st_d.irq_mask = wr_val[1:0];
                default: begin
                end
            endcase
        end
        // set wins over clear
        st_d.irq_st = (st_q.irq_st & ~irq_clr) | irq_set;
        // both result bytes change together
        if (conv_done) begin
            st_d.raw      = conv_res;
            st_d.res_word = st_q.left ? conv_res << JUST_SH : conv_res;
        end
        // analog selection: channel 8 and above is the temperature sensor
        st_d.afe.pwr_en = st_d.en;
        st_d.afe.gain   = st_d.gain;
        st_d.afe.track  = conv_track;
        st_d.afe.trial  = conv_trial;
        if (st_d.chan >= `SACC_TEMP_CHAN) begin
            st_d.afe.pos_sel = `SACC_TEMP_CHAN;
            st_d.afe.neg_sel = 3'h0;
            st_d.afe.diff    = 1'b0;
        end else if (st_d.diff[st_d.chan[2:1]]) begin
            st_d.afe.pos_sel = {1'b0, st_d.chan[2:1], 1'b0};
            st_d.afe.neg_sel = {st_d.chan[2:1], 1'b1};
            st_d.afe.diff    = 1'b1;
        end else begin
            st_d.afe.pos_sel = st_d.chan;
            st_d.afe.neg_sel = 3'h0;
            st_d.afe.diff    = 1'b0;
        end
    end

    // state register
    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_q          <= '0;
            st_q.trig     <= TRIG_SW;
            st_q.chan     <= `SACC_CHAN_RST;
            st_q.gain     <= `SACC_GAIN_RST;
            st_q.win_lo   <= `SACC_WIN_LO_RST;
            st_q.win_hi   <= `SACC_WIN_HI_RST;
            st_q.afe.gain <= `SACC_GAIN_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // bus answers and outputs
    assign avs_readdata    = st_q.rdata;
    assign avs_waitrequest = avs_req.read && !st_q.rd_ack;
    assign afe             = st_q.afe;
    assign irq             = |(st_q.irq_st & st_q.irq_mask);
    assign pin_reset_req   = st_q.rst_en && pin_level;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence idle_en_s;
        !conv_busy && st_q.en;
    endsequence

    sequence conv_runs_s;
        conv_busy [*8];
    endsequence

    // trigger acceptance; a start that also clears enable is aborted one edge later
    sw_trigger_a: assert property (idle_en_s and (st_q.trig == TRIG_SW
        && sw_start && wr_val[`SACC_CTRL_EN]) |=> conv_runs_s)
        else $error("software start not taken");

    pin_trigger_a: assert property (idle_en_s
        and (st_q.trig == TRIG_PIN && pin_rise) |=> conv_busy)
        else $error("pin edge start not taken");

    t2_trigger_a: assert property (idle_en_s
        and (st_q.trig == TRIG_T2 && timer2_ovf) |=> conv_busy)
        else $error("timer 2 start not taken");

    timer_trigger_a: assert property (idle_en_s
        and (st_q.trig == TRIG_T3 && timer3_ovf) |=> conv_busy)
        else $error("timer start not taken");

    // completion flag and interrupt
    done_flag_a: assert property (conv_done |=> st_q.irq_st[`SACC_IRQ_DONE])
        else $error("completion flag missing");

    irq_level_a: assert property (conv_done && st_q.irq_mask[`SACC_IRQ_DONE]
        && !(avs_req.write && avs_req.address == `SACC_IRQ_MASK_OFS) |=> irq)
        else $error("completion interrupt missing");

    flag_clear_a: assert property (irq_clr[`SACC_IRQ_DONE] && !conv_done
        |=> !st_q.irq_st[`SACC_IRQ_DONE])
        else $error("completion flag not cleared");

    // result bytes and alignment
    result_latch_a: assert property (conv_done |=> st_q.raw == $past(conv_res)
        && st_q.res_word[15:8] == $past(st_q.left ? conv_res << JUST_SH : conv_res) >> 8)
        else $error("result bytes not latched together");

    left_just_a: assert property (conv_done && st_q.left
        |=> st_q.res_word[15:JUST_SH] == st_q.raw[RES_W-1:0])
        else $error("left alignment wrong");

    right_just_a: assert property (conv_done && !st_q.left
        |=> st_q.res_word == st_q.raw)
        else $error("right alignment wrong");

    // window compare
    window_hit_a: assert property (conv_done && in_window
        |=> st_q.irq_st[`SACC_IRQ_WIN])
        else $error("window hit not flagged");

    window_miss_a: assert property (!conv_done && !st_q.irq_st[`SACC_IRQ_WIN]
        |=> !st_q.irq_st[`SACC_IRQ_WIN])
        else $error("window flag without hit");

    // front end routing; afe and selection registers move on the same edge
    temp_chan_a: assert property (st_q.chan >= `SACC_TEMP_CHAN
        |-> afe.pos_sel == `SACC_TEMP_CHAN && !afe.diff)
        else $error("temperature channel not routed");

    diff_pair_a: assert property (st_q.chan < `SACC_TEMP_CHAN
        && st_q.diff[st_q.chan[2:1]] |-> afe.diff && afe.neg_sel[0])
        else $error("differential pair not routed");

    gain_range_a: assert property (st_q.gain <= `SACC_GAIN_MAX)
        else $error("gain code out of range");

    gain_sat_a: assert property (avs_req.write && avs_req.address == `SACC_GAIN_OFS
        && wr_val[2:0] > `SACC_GAIN_MAX |=> st_q.gain == `SACC_GAIN_MAX)
        else $error("gain not saturated");

    // shutdown: power follows enable now, sequencer idles one edge later
    shutdown_a: assert property (!st_q.en |-> !afe.pwr_en ##1 !conv_busy)
        else $error("converter active in shutdown");

    pin_reset_a: assert property (!st_q.rst_en |-> !pin_reset_req)
        else $error("pin reset while disabled");

    // bus answers
    read_wait_a: assert property (avs_req.read && !st_q.rd_ack |=> !avs_waitrequest
        || !avs_req.read)
        else $error("read answer late");

    read_data_a: assert property (avs_req.read && !st_q.rd_ack
        |=> avs_readdata == $past(rd_val))
        else $error("read data not captured");

    write_nowait_a: assert property (avs_req.write && !avs_req.read |-> !avs_waitrequest)
        else $error("write stalled");
endmodule : sacc_top
`default_nettype wire

// ==== sacc_afe_model.sv ====
// behavioural analog comparator facing the converter front end
`default_nettype none
module sacc_afe_model (
    // clock for the unpowered pattern
    input  wire logic                core_clk,
    // front end controls from the block
    input  wire sacc_pkg::sacc_afe_t afe,
    // analog level in right aligned code units
    input  wire logic [15:0]         level,
    // comparator decision, 1 when level >= trial while powered, toggling each clock when unpowered
    output logic                     cmp_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import sacc_pkg::*;

    logic noise_q = 1'b0;

    // unpowered comparator toggles so a stale decision never passes
    always_ff @(posedge core_clk) begin
        noise_q <= ~noise_q;
    end

    // powered comparator judges level against the trial code
    assign cmp_out = afe.pwr_en ? (level >= afe.trial) : noise_q;
endmodule : sacc_afe_model
`default_nettype wire

// ==== tb.sv ====
// self-checking bench for the conversion control block
`default_nettype none
`include "sacc_defs.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import sacc_pkg::*;

    localparam int CC = 128; // shortened; 8-cycle bit slot outlasts comparator sync delay

    logic          core_clk;
    logic          reset;
    logic          t2;
    logic          t3;
    logic          pin;
    logic          cmp_out;
    logic          pin_rst;
    logic          irq;
    logic          wq;
    logic [31:0]   rdat;
    logic [31:0]   v;
    logic [15:0]   level;
    sacc_avs_req_t req;
    sacc_afe_t     afe;
    int            n;
    int            miscompares;
    int            tests_run;

    sacc_top #(.CONV_CYC(CC)) dut (.core_clk(core_clk), .reset(reset), .avs_req(req),
        .avs_readdata(rdat), .avs_waitrequest(wq), .timer2_ovf(t2), .timer3_ovf(t3),
        .external_convert_start_pin(pin), .cmp_out(cmp_out), .afe(afe),
        .pin_reset_req(pin_rst), .irq(irq));

    sacc_afe_model mdl (.core_clk(core_clk), .afe(afe), .level(level), .cmp_out(cmp_out));

    // 200 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // compare and count
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // bus access held until waitrequest is seen low
    task acc(input logic is_wr, input logic [5:0] a, input logic [31:0] d);
        req.address   <= a;
        req.writedata <= d;
        req.byteenable <= 4'hF;
        req.write     <= is_wr;
        req.read      <= ~is_wr;
        do begin
            @(posedge core_clk);
        end while (wq !== 1'b0);
        v = rdat;
        req.write <= 1'b0;
        req.read  <= 1'b0;
        @(posedge core_clk);
    endtask : acc

    task wr(input logic [5:0] a, input logic [31:0] d);
        acc(1'b1, a, d);
    endtask : wr

    task rc(input logic [5:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        chk(v, e);
    endtask : rc

    // result byte pair against the expected word
    task res(input logic [15:0] e);
        rc(`SACC_RES_LO_OFS, {24'h0, e[7:0]});
        rc(`SACC_RES_HI_OFS, {24'h0, e[15:8]});
    endtask : res

    // cycles until the completion interrupt shows
    task wait_done();
        logic w;
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
            w = irq;
            @(posedge core_clk);
        end while (w !== 1'b1 && n < 1000);
    endtask : wait_done

    // one trigger source: 1 timer 2, 2 timer 3, 3 pin
    task pulse(input int k);
        t2  <= (k == 1);
        t3  <= (k == 2);
        pin <= (k == 3);
        repeat (k == 3 ? 4 : 1) @(posedge core_clk);
        t2  <= 1'b0;
        t3  <= 1'b0;
        pin <= 1'b0;
        @(posedge core_clk);
    endtask : pulse

    task close_out();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out

    // hang guard
    initial begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        close_out();
    end

    // main sequence
    initial begin
        reset = 1'b1;
        t2 = 1'b0;
        t3 = 1'b0;
        pin = 1'b0;
        level = 16'h0;
        req = '0;
        miscompares = 0;
        tests_run = 0;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        rc(`SACC_GAIN_OFS, 32'h1);
        rc(`SACC_WIN_HI_OFS, 32'hFFFF);
        rc(`SACC_STATUS_OFS, 32'h0);
        rc(6'h3C, 32'h0);
        wr(`SACC_CTRL_OFS, 32'h10);
        repeat (CC + 20) @(posedge core_clk);
        rc(`SACC_IRQ_ST_OFS, 32'h0);
        $display("test reset_shutdown done");
        wr(`SACC_CHAN_OFS, 32'h8);
        @(negedge core_clk);
        chk({28'h0, afe.pos_sel}, 32'h8);
        @(posedge core_clk);
        wr(`SACC_DIFF_OFS, 32'h2);
        wr(`SACC_CHAN_OFS, 32'h2);
        @(negedge core_clk);
        chk({24'h0, afe.pos_sel, afe.diff, afe.neg_sel}, 32'h2B);
        @(posedge core_clk);
        for (int g = 0; g < 6; g++) begin
            wr(`SACC_GAIN_OFS, 32'(g));
            @(negedge core_clk);
            chk({29'h0, afe.gain}, 32'(g));
            @(posedge core_clk);
        end
        wr(`SACC_GAIN_OFS, 32'h7);
        rc(`SACC_GAIN_OFS, 32'h5);
        wr(`SACC_DIFF_OFS, 32'h0);
        $display("test mux_gain done");
        wr(`SACC_WIN_LO_OFS, 32'hA00);
        wr(`SACC_WIN_HI_OFS, 32'hAFF);
        wr(`SACC_IRQ_MASK_OFS, 32'h1);
        wr(`SACC_CTRL_OFS, 32'h1);
        level <= 16'hA5C;
        wr(`SACC_CTRL_OFS, 32'h11);
        wait_done();
        chk(32'(n >= CC - 4 && n <= CC + 8), 32'h1);
        rc(`SACC_IRQ_ST_OFS, 32'h3);
        res(16'hA5C);
        rc(`SACC_STATUS_OFS, 32'h2);
        wr(`SACC_IRQ_ST_OFS, 32'h3);
        @(negedge core_clk);
        chk({31'h0, irq}, 32'h0);
        @(posedge core_clk);
        level <= 16'h123;
        wr(`SACC_CTRL_OFS, 32'h13);
        wait_done();
        rc(`SACC_IRQ_ST_OFS, 32'h1);
        res(16'h1230);
        $display("test result_window done");
        wr(`SACC_IRQ_ST_OFS, 32'h3);
        wr(`SACC_CTRL_OFS, 32'h11);
        repeat (10) @(posedge core_clk);
        rc(`SACC_STATUS_OFS, 32'h3);
        wr(`SACC_CTRL_OFS, 32'h11);
        wait_done();
        chk(32'(n < CC - 6), 32'h1);
        wr(`SACC_IRQ_ST_OFS, 32'h3);
        repeat (CC + 20) @(posedge core_clk);
        rc(`SACC_IRQ_ST_OFS, 32'h0);
        $display("test busy_retrigger done");
        for (int k = 1; k < 4; k++) begin
            wr(`SACC_IRQ_ST_OFS, 32'h3);
            wr(`SACC_CTRL_OFS, 32'(k * 4 + 1));
            pulse(k % 3 + 1);
            rc(`SACC_STATUS_OFS, 32'h2);
            pulse(k);
            wait_done();
            rc(`SACC_IRQ_ST_OFS, 32'h1);
        end
        $display("test triggers done");
        wr(`SACC_IRQ_ST_OFS, 32'h3);
        wr(`SACC_CTRL_OFS, 32'h11);
        repeat (10) @(posedge core_clk);
        wr(`SACC_CTRL_OFS, 32'h0);
        repeat (CC + 20) @(posedge core_clk);
        rc(`SACC_IRQ_ST_OFS, 32'h0);
        @(negedge core_clk);
        chk({31'h0, afe.pwr_en}, 32'h0);
        @(posedge core_clk);
        $display("test abort done");
        wr(`SACC_CTRL_OFS, 32'h20);
        pin <= 1'b1;
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        chk({31'h0, pin_rst}, 32'h1);
        @(posedge core_clk);
        wr(`SACC_CTRL_OFS, 32'h0);
        @(negedge core_clk);
        chk({31'h0, pin_rst}, 32'h0);
        @(posedge core_clk);
        pin <= 1'b0;
        $display("test pin_reset done");
        close_out();
    end
endmodule : tb
`default_nettype wire
